/* File: core/fbo_regs.vh */
`ifndef FBO_REGS_VH
`define FBO_REGS_VH

// synchronised control pin vector, bit positions
`define FBO_B_CE 7
`define FBO_B_OE 6
`define FBO_B_WE 5
`define FBO_B_RST 4
`define FBO_B_BCLK 3
`define FBO_B_ADV 2
`define FBO_B_WP 1
`define FBO_B_ID 0
// idle pin pattern: deselected, strobes high, reset held low, clock low
`define FBO_CTL_IDLE 8'he6

// widths
`define FBO_AW 20
`define FBO_DW 32

// protection status read: offset on address bits 7..0
`define FBO_PROT_OFS 8'h02
`define FBO_PROT_MSB 7
// protection word: bits 31..2 read as zero
`define FBO_PROT_PAD 30'h00000000

// boot block: sector field addr[19:12] selecting the one outermost sector, ff for top boot or 00 for bottom
`define FBO_BOOT_MSB 19
`define FBO_BOOT_LSB 12
`define FBO_BOOT_TOP 8'hff
`define FBO_BOOT_BOT 8'h00

// busy recovery after a reset that hit a program or erase
`define FBO_CLK_NS 20
`define FBO_T_BUSY_REC_NS 20000
`define FBO_REC_W 10
`define FBO_REC_ZERO 10'h000
`define FBO_REC_ONE 10'h001

// reset values
`define FBO_A_ZERO 20'h00000
`define FBO_A_ONE 20'h00001
`define FBO_D_ZERO 32'h00000000

`endif

/* File: core/fbo_buf2.v */
`timescale 1ns/1ps
`include "fbo_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// two-entry buffer, head in slot 0; every output straight from a flip-flop
module fbo_buf2 #(
	parameter W = 53
) (
	input wire clk,
	input wire rst,
	input wire in_valid,
	output wire in_ready,
	input wire [W-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [W-1:0] out_data
);

reg v0_q; // head slot holds a word
reg v1_q; // second slot holds a word
reg [W-1:0] d0_q;
reg [W-1:0] d1_q;
wire push;
wire pop;

assign in_ready = ~v1_q; // full only when both slots are taken
assign out_valid = v0_q;
assign out_data = d0_q;
assign push = in_valid & ~v1_q;
assign pop = v0_q & out_ready;

// shift on pop, fill the lowest free slot on push
always @(posedge clk or posedge rst) begin
	if (rst) begin
		v0_q <= 1'b0;
		v1_q <= 1'b0;
		d0_q <= {W{1'b0}};
		d1_q <= {W{1'b0}};
	end else begin
		if (pop) begin
			// head leaves; slot 1 (or the new word) moves up
			v0_q <= v1_q | push;
			d0_q <= v1_q ? d1_q : in_data;
			v1_q <= v1_q & push;
			if (v1_q & push) begin
				d1_q <= in_data;
			end
		end else if (push) begin
			if (v0_q) begin
				v1_q <= 1'b1;
				d1_q <= in_data;
			end else begin
				v0_q <= 1'b1;
				d0_q <= in_data;
			end
		end
	end
end

endmodule

/* File: core/fbo_core.v */
`timescale 1ns/1ps
`include "fbo_regs.vh"

// Function
// RL1 - operations start from command writes into latches
// RL2 - bad sequences need the reset command
// RL3 - data driven only while chip selected
// RL4 - data out only with output gate low
// RL5 - status offset returns persistent and volatile bits
// RL6 - write-protect guards two outermost boot sectors; code guards only the outermost one (ff top boot, 00 bottom boot)
// RL7 - reset and power-up enter asynchronous array read
// RL8 - random single-location reads need no command
// RL9 - array read holds until a command write
// RL10 - reset aborts any mode or operation
// RL11 - data outputs float while reset held
// RL12 - ready/busy low until reset sequence completes; code holds it low only after a reset that hit a busy core (core_busy)
// RL13 - idle bank readable after short recovery
// RL14 - busy bank waits longer recovery after reset
// RL15 - reset mid-operation corrupts target, host rewrites
// RL16 - host holds reset during supply ramp
// RL17 - address-valid with clock loads burst address
// RL18 - clock edges advance burst, address ignored
// RL19 - chip deselect ends burst, bus floats
// RL20 - reset ends burst, bus floats
// RL21 - new address-valid pulse restarts burst
// RL22 - reset clears burst configuration, async read
// RL23 - command write: select, strobe low, gate high
module fbo_core #(
	parameter TOP_BOOT = 1,
	parameter T_BUSY_REC_NS = `FBO_T_BUSY_REC_NS
) (
	input wire clk,
	input wire rst,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire reset_n,
	input wire burst_clk,
	input wire address_valid_n,
	input wire wp_n,
	input wire elevated_identifier_level,
	input wire [`FBO_AW-1:0] addr,
	input wire [`FBO_DW-1:0] dq_in,
	output wire [`FBO_DW-1:0] dq_out,
	output wire dq_oe,
	output wire ready_busy_n,
	output wire [`FBO_AW-1:0] array_addr,
	input wire [`FBO_DW-1:0] array_data,
	input wire [`FBO_DW-1:0] status_data,
	input wire persistent_protect_bit,
	input wire volatile_protect_bit,
	input wire core_busy,
	input wire cmd_done,
	input wire burst_mode_set,
	output wire burst_mode,
	output wire cfg_clear,
	output wire cmd_valid,
	input wire cmd_ready,
	output wire [`FBO_AW-1:0] cmd_addr,
	output wire [`FBO_DW-1:0] cmd_data,
	output wire cmd_wp_guard
);

// busy recovery in cycles, a least time so rounded up
localparam integer REC_CYC = (T_BUSY_REC_NS + `FBO_CLK_NS - 1) / `FBO_CLK_NS;
localparam [`FBO_REC_W-1:0] REC_LOAD = REC_CYC[`FBO_REC_W-1:0];
localparam integer CW = 1 + `FBO_AW + `FBO_DW; // guard flag, address, data

// one-hot recovery states
localparam [2:0] ST_IDLE = 3'b001;
localparam [2:0] ST_HOLD = 3'b010;
localparam [2:0] ST_COUNT = 3'b100;

////////////////////////////////////////////////////////////////////////////////
// pin synchronisers: every host pin passes two flops before use

reg [7:0] ctl_s1_q; // first stage, read only by the second
reg [7:0] ctl_s2_q;
reg [`FBO_AW-1:0] adr_s1_q;
reg [`FBO_AW-1:0] adr_s2_q;
reg [`FBO_DW-1:0] din_s1_q;
reg [`FBO_DW-1:0] din_s2_q;

// buses are sampled independently of the strobes; the host must hold
// address and data stable a few clocks around each strobe edge
always @(posedge clk or posedge rst) begin
	if (rst) begin
		ctl_s1_q <= `FBO_CTL_IDLE;
		ctl_s2_q <= `FBO_CTL_IDLE;
		adr_s1_q <= `FBO_A_ZERO;
		adr_s2_q <= `FBO_A_ZERO;
		din_s1_q <= `FBO_D_ZERO;
		din_s2_q <= `FBO_D_ZERO;
	end else begin
		ctl_s1_q <= {ce_n, oe_n, we_n, reset_n, burst_clk, address_valid_n, wp_n,
			elevated_identifier_level};
		ctl_s2_q <= ctl_s1_q;
		adr_s1_q <= addr;
		adr_s2_q <= adr_s1_q;
		din_s1_q <= dq_in;
		din_s2_q <= din_s1_q;
	end
end

// decoded pin levels, all from the second stage
wire sel = ~ctl_s2_q[`FBO_B_CE];
wire gate_lo = ~ctl_s2_q[`FBO_B_OE];
wire strobe_lo = ~ctl_s2_q[`FBO_B_WE];
wire hw_rst = ~ctl_s2_q[`FBO_B_RST];
wire adv_lo = ~ctl_s2_q[`FBO_B_ADV];
wire wp_lo = ~ctl_s2_q[`FBO_B_WP];
wire id_hi = ctl_s2_q[`FBO_B_ID];

////////////////////////////////////////////////////////////////////////////////
// edge detection on the burst clock and on the write condition

reg bclk_q; // previous burst clock level
reg wr_q; // previous write condition
wire bclk_rise = ctl_s2_q[`FBO_B_BCLK] & ~bclk_q;
wire wr_cond = sel & strobe_lo & ~gate_lo & ~hw_rst; // RL23
wire wr_rise = wr_cond & ~wr_q;

// edge history
always @(posedge clk or posedge rst) begin
	if (rst) begin
		bclk_q <= 1'b0;
		wr_q <= 1'b0;
	end else begin
		bclk_q <= ctl_s2_q[`FBO_B_BCLK];
		wr_q <= wr_cond;
	end
end

////////////////////////////////////////////////////////////////////////////////
// command path: each write strobe pushes one address/data pair unless both slots are full

wire boot_hit;
wire wp_guard;
wire buf_in_ready;
wire [CW-1:0] buf_out;

// outermost boot sectors depend on the top or bottom variant
assign boot_hit = (TOP_BOOT != 0) ?
	(adr_s2_q[`FBO_BOOT_MSB:`FBO_BOOT_LSB] == `FBO_BOOT_TOP) :
	(adr_s2_q[`FBO_BOOT_MSB:`FBO_BOOT_LSB] == `FBO_BOOT_BOT);
assign wp_guard = wp_lo & boot_hit; // RL6

// the buffer decouples the host strobe from a stalled command engine;
// when full, ready/busy drops so the host holds off its next write
fbo_buf2 #(
	.W(CW)
) u_cmd_buf (
	.clk(clk),
	.rst(rst),
	.in_valid(wr_rise), // RL1
	.in_ready(buf_in_ready),
	.in_data({wp_guard, adr_s2_q, din_s2_q}),
	.out_valid(cmd_valid),
	.out_ready(cmd_ready),
	.out_data(buf_out)
);

assign cmd_wp_guard = buf_out[CW-1];
assign cmd_addr = buf_out[CW-2:`FBO_DW];
assign cmd_data = buf_out[`FBO_DW-1:0];

////////////////////////////////////////////////////////////////////////////////
// read mode: array read until a command is written, back on done or reset

reg cmd_mode_q; // reads return engine status instead of array data
reg burst_mode_q; // synchronous read enabled by the configuration logic
reg cfg_clear_q; // tells the configuration logic to fall back to defaults

// the set from a new write wins over a done in the same cycle
always @(posedge clk or posedge rst) begin
	if (rst) begin
		cmd_mode_q <= 1'b0; // RL7
		burst_mode_q <= 1'b0;
		cfg_clear_q <= 1'b1;
	end else begin
		cfg_clear_q <= hw_rst;
		if (hw_rst) begin
			// a pin reset drops every mode and reverts to async reads
			cmd_mode_q <= 1'b0; // RL10
			burst_mode_q <= 1'b0; // RL22
		end else begin
			if (wr_rise) begin
				cmd_mode_q <= 1'b1; // RL9
			end else if (cmd_done) begin
				cmd_mode_q <= 1'b0; // RL2
			end
			if (burst_mode_set) begin
				burst_mode_q <= 1'b1;
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// burst sequencer: load, advance, terminate, restart

reg burst_act_q; // a burst is in progress
reg [`FBO_AW-1:0] burst_addr_q; // current burst location

// load and restart share one branch: a fresh address-valid simply
// overwrites the running burst
always @(posedge clk or posedge rst) begin
	if (rst) begin
		burst_act_q <= 1'b0;
		burst_addr_q <= `FBO_A_ZERO;
	end else if (hw_rst) begin
		burst_act_q <= 1'b0; // RL20
	end else if (~sel) begin
		burst_act_q <= 1'b0; // RL19
	end else if (bclk_rise & ~strobe_lo & adv_lo & burst_mode_q) begin
		// output gate is ignored here
		burst_act_q <= 1'b1; // RL17 RL21
		burst_addr_q <= adr_s2_q;
	end else if (bclk_rise & gate_lo & ~strobe_lo & ~adv_lo & burst_act_q) begin
		// address pins ignored while advancing
		burst_addr_q <= burst_addr_q + `FBO_A_ONE; // RL18
	end
end

////////////////////////////////////////////////////////////////////////////////
// read data path: address and enable out together, data back one cycle later

reg [`FBO_AW-1:0] array_addr_q;
reg prot_q; // the present read is a protection status read
reg cmd_rd_q; // the present read returns engine status
reg [`FBO_DW-1:0] dq_q;
reg dq_oe_q;
wire rd_ok = sel & gate_lo & ~strobe_lo & ~hw_rst; // RL3 RL4 RL11
wire prot_rd = id_hi & (adr_s2_q[`FBO_PROT_MSB:0] == `FBO_PROT_OFS);

// protection reads stay single-cycle even in burst mode
always @(posedge clk or posedge rst) begin
	if (rst) begin
		array_addr_q <= `FBO_A_ZERO;
		prot_q <= 1'b0;
		cmd_rd_q <= 1'b0;
		dq_q <= `FBO_D_ZERO;
		dq_oe_q <= 1'b0;
	end else begin
		// random async address unless a burst owns the array port
		array_addr_q <= burst_act_q ? burst_addr_q : adr_s2_q; // RL8
		prot_q <= prot_rd;
		cmd_rd_q <= cmd_mode_q;
		dq_oe_q <= rd_ok;
		if (prot_q) begin
			dq_q <= {`FBO_PROT_PAD, volatile_protect_bit, persistent_protect_bit}; // RL5
		end else if (cmd_rd_q) begin
			dq_q <= status_data;
		end else begin
			dq_q <= array_data;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// reset recovery: a reset that hit a program or erase keeps ready/busy low

reg [2:0] rec_st_q;
reg [2:0] rec_st_d;
reg [`FBO_REC_W-1:0] rec_cnt_q;
reg [`FBO_REC_W-1:0] rec_cnt_d;
reg rb_n_q;

// next state: hold while reset is low, then count the recovery time
always @* begin
	rec_st_d = rec_st_q;
	rec_cnt_d = rec_cnt_q;
	case (rec_st_q)
	ST_IDLE: begin
		if (hw_rst & core_busy) begin // RL15
			rec_st_d = ST_HOLD; // RL12
		end
	end
	ST_HOLD: begin
		if (~hw_rst) begin
			rec_st_d = ST_COUNT;
			rec_cnt_d = REC_LOAD;
		end
	end
	ST_COUNT: begin
		if (hw_rst) begin
			// a second reset restarts the wait
			rec_st_d = ST_HOLD;
		end else if (rec_cnt_q == `FBO_REC_ONE) begin
			rec_st_d = ST_IDLE; // RL14
			rec_cnt_d = `FBO_REC_ZERO;
		end else begin
			rec_cnt_d = rec_cnt_q - `FBO_REC_ONE;
		end
	end
	default: begin
		rec_st_d = ST_IDLE;
		rec_cnt_d = `FBO_REC_ZERO;
	end
	endcase
end

// state flops and the ready/busy pin; a full command buffer also reads busy
always @(posedge clk or posedge rst) begin
	if (rst) begin
		rec_st_q <= ST_IDLE;
		rec_cnt_q <= `FBO_REC_ZERO;
		rb_n_q <= 1'b1;
	end else begin
		rec_st_q <= rec_st_d;
		rec_cnt_q <= rec_cnt_d;
		rb_n_q <= ~(core_busy | (rec_st_d != ST_IDLE) | ~buf_in_ready); // RL12
	end
end

////////////////////////////////////////////////////////////////////////////////
// outputs

assign dq_out = dq_q;
assign dq_oe = dq_oe_q;
assign ready_busy_n = rb_n_q;
assign array_addr = array_addr_q;
assign burst_mode = burst_mode_q;
assign cfg_clear = cfg_clear_q;

endmodule

/* File: tb/fbo_core_asserts.sv */
`timescale 1ns/1ps
// pins reach outputs after two sync flops and one register
module fbo_core_asserts (
	input wire clk,
	input wire rst,
	input wire ce_n,
	input wire oe_n,
	input wire we_n,
	input wire reset_n,
	input wire [19:0] addr,
	input wire dq_oe,
	input wire ready_busy_n,
	input wire [19:0] array_addr,
	input wire core_busy,
	input wire burst_mode,
	input wire cfg_clear,
	input wire cmd_valid,
	input wire cmd_ready,
	input wire [19:0] cmd_addr,
	input wire [31:0] cmd_data
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////
	oe_needs_sel_a: assert property (
		dq_oe |-> !$past(ce_n, 3) && !$past(oe_n, 3) && $past(reset_n, 3))
		else $error("drive without selected read");
	we_blocks_a: assert property (!$past(we_n, 3) |-> !dq_oe)
		else $error("drive during write strobe");
	rst_float_a: assert property (!$past(reset_n, 3) |-> !dq_oe && cfg_clear)
		else $error("reset pin not honoured");
	rst_burst_a: assert property (!$past(reset_n, 3) |-> !burst_mode)
		else $error("burst mode kept in reset");
	addr_follow_a: assert property (
		!burst_mode && !$past(burst_mode, 4) |-> array_addr == $past(addr, 3))
		else $error("array address lags");
	cmd_taken_a: assert property (
		$rose(cmd_valid) |-> !$past(ce_n, 3) && !$past(we_n, 3) && $past(oe_n, 3))
		else $error("command without write");
	cmd_hold_a: assert property (
		cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_addr) && $stable(cmd_data))
		else $error("command lost under stall");
	busy_flag_a: assert property (core_busy ##1 core_busy |=> !ready_busy_n)
		else $error("ready while busy");
endmodule

bind fbo_core fbo_core_asserts i_chk (
	.clk(clk), .rst(rst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
	.addr(addr), .dq_oe(dq_oe), .ready_busy_n(ready_busy_n), .array_addr(array_addr),
	.core_busy(core_busy), .burst_mode(burst_mode), .cfg_clear(cfg_clear),
	.cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_data(cmd_data)
);

/* File: tb/fbo_host.sv */
`timescale 1ns/1ps
// host controller; pins move just after clk edges
module fbo_host (
	input wire clk,
	output reg ce_n,
	output reg oe_n,
	output reg we_n,
	output reg reset_n,
	output reg burst_clk,
	output reg address_valid_n,
	output reg [19:0] addr,
	output reg [31:0] dq_in
);
	reg run; // burst clock only inside a frame
	initial begin
		{ce_n, oe_n, we_n, address_valid_n} = 4'hf;
		reset_n = 1'b0;
		{run, burst_clk} = 2'h0;
		addr = 20'h00000;
		dq_in = 32'h00000000;
	end
	// 160 ns, edges fall on clk falling edges, parked low
	always #80 burst_clk = run ? ~burst_clk : 1'b0;
	task set_rst(input v);
		begin
			@(posedge clk);
			reset_n <= v;
		end
	endtask
	// strobe held long enough for the sampler; data then flips
	task wr(input [19:0] a, input [31:0] d);
		begin
			@(posedge clk);
			addr <= a;
			dq_in <= d;
			{ce_n, we_n} <= 2'h0;
			repeat (4) @(posedge clk);
			{ce_n, we_n} <= 2'h3;
			dq_in <= ~d;
			repeat (2) @(posedge clk);
		end
	endtask
	task sel(input [19:0] a, input on);
		begin
			@(posedge clk);
			addr <= a;
			{ce_n, oe_n} <= {2{~on}};
		end
	endtask
	// load on first rise with gate high, then n advances
	task burst(input [19:0] a, input integer n);
		begin
			@(posedge clk);
			addr <= a;
			{ce_n, oe_n, address_valid_n, run} <= 4'h5;
			@(posedge burst_clk);
			@(posedge clk);
			{address_valid_n, oe_n} <= 2'h2;
			addr <= ~a;
			repeat (n) @(posedge burst_clk);
			run <= 1'b0;
		end
	endtask
endmodule

/* File: tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg wp_n = 1'b1;
	reg elevated_identifier_level = 1'b0;
	reg [31:0] status_data = 32'h5a0f3c96;
	reg persistent_protect_bit = 1'b0;
	reg volatile_protect_bit = 1'b0;
	reg core_busy = 1'b0;
	reg cmd_done = 1'b0;
	reg burst_mode_set = 1'b0;
	reg cmd_ready = 1'b0;
	wire ce_n, oe_n, we_n, reset_n, burst_clk, address_valid_n;
	wire dq_oe, ready_busy_n, burst_mode, cfg_clear, cmd_valid, cmd_wp_guard;
	wire [19:0] addr, array_addr, cmd_addr;
	wire [31:0] dq_in, dq_out, cmd_data;
	integer failures = 0;
	integer comparisons = 0;
	integer cyc = 0;
	integer i;
	reg [31:0] rs = 32'h0001178b; // lfsr state
	reg [19:0] a;
	reg [52:0] got [$]; // popped commands
	always #10 clk = ~clk;
	// array word names its own address
	function [31:0] word_of(input [19:0] x);
		word_of = {~x[11:0], x};
	endfunction
	function [31:0] nx(input [31:0] s);
		nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	wire [31:0] array_data = word_of(array_addr);
	fbo_host i_fbo_host (
		.clk(clk), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
		.burst_clk(burst_clk), .address_valid_n(address_valid_n), .addr(addr), .dq_in(dq_in)
	);
	fbo_core #(
		.T_BUSY_REC_NS(200)
	) i_fbo_core (
		.clk(clk), .rst(rst), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .reset_n(reset_n),
		.burst_clk(burst_clk), .address_valid_n(address_valid_n), .wp_n(wp_n),
		.elevated_identifier_level(elevated_identifier_level), .addr(addr), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .ready_busy_n(ready_busy_n),
		.array_addr(array_addr), .array_data(array_data), .status_data(status_data),
		.persistent_protect_bit(persistent_protect_bit),
		.volatile_protect_bit(volatile_protect_bit), .core_busy(core_busy),
		.cmd_done(cmd_done), .burst_mode_set(burst_mode_set), .burst_mode(burst_mode),
		.cfg_clear(cfg_clear), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
		.cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_wp_guard(cmd_wp_guard)
	);
	////////////////////////////////////////
	// capture pops; cut a hang short
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cmd_valid && cmd_ready)
			got.push_back({cmd_wp_guard, cmd_addr, cmd_data});
		if (cyc == 6000) begin
			failures = failures + 1;
			close_out;
		end
	end
	task chk(input [31:0] g, input [31:0] e);
		begin
			comparisons = comparisons + 1;
			if (g !== e) begin
				failures = failures + 1;
				$display("wrong value at %0t: got %h want %h", $time, g, e);
			end
		end
	endtask
	task done_t(input [8*14-1:0] n);
		$display("test %0s end", n);
	endtask
	task rd_chk(input [19:0] x, input [31:0] e);
		begin
			i_fbo_host.sel(x, 1'b1);
			repeat (6) @(posedge clk);
			chk({31'h0, dq_oe}, 32'h1);
			chk(dq_out, e);
			i_fbo_host.sel(x, 1'b0);
			repeat (3) @(posedge clk);
		end
	endtask
	task burst_chk(input [19:0] e);
		begin
			repeat (8) @(posedge clk);
			chk({12'h0, array_addr}, {12'h0, e});
			chk(dq_out, word_of(e));
			chk({30'h0, burst_mode, dq_oe}, 32'h3);
		end
	endtask
	task close_out;
		begin
			$display("comparisons %0d failures %0d", comparisons, failures);
			if (failures == 0 && comparisons > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	////////////////////////////////////////
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		chk({28'h0, ready_busy_n, cfg_clear, dq_oe, cmd_valid}, 32'hc);
		i_fbo_host.set_rst(1'b1);
		done_t("reset");
		for (i = 0; i < 6; i = i + 1) begin
			rs = nx(rs);
			rd_chk(rs[19:0], word_of(rs[19:0]));
		end
		done_t("async read");
		elevated_identifier_level <= 1'b1;
		for (i = 0; i < 4; i = i + 1) begin
			{volatile_protect_bit, persistent_protect_bit} <= i[1:0];
			rd_chk({rs[19:8], 8'h02}, {30'h0, i[1:0]});
		end
		elevated_identifier_level <= 1'b0;
		done_t("protect read");
		// stalled receiver: third write finds both slots full
		wp_n <= 1'b0;
		i_fbo_host.wr(20'hff123, rs);
		wp_n <= rs[3];
		i_fbo_host.wr(20'hff456, ~rs);
		wp_n <= 1'b1;
		i_fbo_host.wr(20'h00abc, 32'h0);
		chk({31'h0, ready_busy_n}, 32'h0);
		cmd_ready <= 1'b1;
		repeat (6) @(posedge clk);
		cmd_ready <= 1'b0;
		chk(got.size(), 32'h2);
		chk({11'h0, got[0][52:32]}, 32'h001ff123);
		chk({11'h0, got[1][52:32]}, {11'h0, ~rs[3], 20'hff456});
		chk(got[0][31:0], rs);
		chk(got[1][31:0], ~rs);
		chk({31'h0, ready_busy_n}, 32'h1);
		status_data <= {rs[15:0], rs[31:16]};
		rd_chk(20'h00100, {rs[15:0], rs[31:16]});
		cmd_done <= 1'b1;
		@(posedge clk);
		cmd_done <= 1'b0;
		rd_chk(20'h00100, word_of(20'h00100));
		done_t("command write");
		burst_mode_set <= 1'b1;
		@(posedge clk);
		burst_mode_set <= 1'b0;
		rs = nx(rs);
		a = rs[19:0];
		i_fbo_host.burst(a, 3);
		burst_chk(a + 20'h3);
		i_fbo_host.burst(~a, 2);
		burst_chk(~a + 20'h2);
		i_fbo_host.sel(a, 1'b0);
		repeat (5) @(posedge clk);
		chk({31'h0, dq_oe}, 32'h0);
		chk({12'h0, array_addr}, {12'h0, a});
		i_fbo_host.burst(a, 1);
		i_fbo_host.set_rst(1'b0);
		repeat (4) @(posedge clk);
		chk({29'h0, dq_oe, burst_mode, cfg_clear}, 32'h1);
		i_fbo_host.set_rst(1'b1);
		repeat (3) @(posedge clk);
		rd_chk(a, word_of(a));
		done_t("burst");
		// reset that lands on a running program
		core_busy <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, ready_busy_n}, 32'h0);
		i_fbo_host.set_rst(1'b0);
		repeat (4) @(posedge clk);
		core_busy <= 1'b0;
		i_fbo_host.set_rst(1'b1);
		repeat (6) @(posedge clk);
		chk({31'h0, ready_busy_n}, 32'h0);
		repeat (20) @(posedge clk);
		chk({31'h0, ready_busy_n}, 32'h1);
		i_fbo_host.wr(a, rs);
		chk({10'h0, cmd_valid, cmd_wp_guard, cmd_addr}, {11'h1, 1'b0, a});
		chk(cmd_data, rs);
		done_t("busy reset");
		close_out;
	end
endmodule
